//--- design/pms_memory_map.sv
/*
 * pms_memory_map: code flash with boot/application split, secure area access control,
 * internal and extended data RAM, reset and vector address generation.
 * Assumes the core and programming paths share one request port, one request per cycle,
 * all inputs synchronous to ref_clk.
 */
// Notes on behaviour
// - after reset fetch starts at logical 0000H of the selected boot area
// - interrupt vectors at 0003H plus eight bytes per interrupt number
// - data accesses use storage separate from program memory
// - 256 bytes of internal scratch-pad RAM
// - 2 Kbytes of extended data RAM reached only by external-data moves
// - flash pages are 128 bytes, erase clears a whole page
// - flash supports erase, program and read
// - application area serves fetches and code-memory reads
// - booting from loader area maps 0000H and vectors into that area
// - three-bit size field splits flash: none, 1K, 2K, 3K, 4K loader
// - any page may hold non-volatile data via in-application accesses
// - secure area is FF80H-FFFFH and survives whole-chip erase
// - secure area is secured unless its last byte reads FFH
// - non-secured: secure area is read, erased, programmed like other code
// - secured: data reads give 00H unless executing from secure area
// - secured with debug connected: fetches from secure area give zero
// - secured: programming-port read, program and erase of secure area refused
`timescale 1ns/1ps
module pms_memory_map (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // boot strap taken at reset release; debug flag used live
    input wire logic bootFromLoader,
    input wire logic debugConnected,
    // loader_size_config byte
    input wire logic cfgWe,
    input wire logic [7:0] cfgWdata,
    output logic [7:0] cfgRdata_ff,
    // interrupt vector request
    input wire logic vecReq,
    input wire logic [4:0] vecNum,
    output logic [15:0] vectorPc_ff,
    // memory request and answer
    input wire pms_pkg::pms_req_t req,
    output pms_pkg::pms_rsp_t rsp_ff,
    // status
    output logic [15:0] resetPc_ff,
    output logic secured_ff,
    output logic bootLoader_ff,
    output logic runFromSecure_ff
);
    pms_pkg::pms_state_t state_ff;
    logic [2:0] loaderSel_ff;
    logic [2:0] bootSel_ff;
    logic [7:0] flashMem_ff [pms_pkg::FLASH_BYTES];
    logic [7:0] secMem_ff [pms_pkg::SEC_BYTES];
    logic [7:0] iramMem_ff [pms_pkg::IRAM_BYTES];
    logic [7:0] xramMem_ff [pms_pkg::EXTENDED_DATA_RAM_BYTES];
    logic secured;
    logic running;
    logic [15:0] loader_size_select;
    logic [15:0] ldBase;
    logic [15:0] physAddr;
    logic physOk;
    logic isSec;
    logic secAllowCpu;
    logic ispBlocked;
    pms_pkg::pms_rsp_t nxt_rsp;

    // loader size in bytes for a size code
    function automatic logic [15:0] loaderBytes(input logic [2:0] sel);
        case (sel)
            pms_pkg::LDSEL_NONE: loaderBytes = pms_pkg::LD_SIZE_0K;
            pms_pkg::LDSEL_1K: loaderBytes = pms_pkg::LD_SIZE_1K;
            pms_pkg::LDSEL_2K: loaderBytes = pms_pkg::LD_SIZE_2K;
            pms_pkg::LDSEL_3K: loaderBytes = pms_pkg::LD_SIZE_3K;
            default: loaderBytes = pms_pkg::LD_SIZE_4K;
        endcase
    endfunction

    // true when an address falls in the secure area
    function automatic logic inSecure(input logic [15:0] a);
        inSecure = (a >= pms_pkg::SEC_BASE);
    endfunction

    // sequencing: one settle cycle after reset to take straps
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff <= pms_pkg::ST_BOOT;
        end else begin
            case (state_ff)
                pms_pkg::ST_BOOT: state_ff <= pms_pkg::ST_RUN;
                pms_pkg::ST_RUN: state_ff <= pms_pkg::ST_RUN;
                default: state_ff <= pms_pkg::ST_BOOT;
            endcase
        end
    end
    assign running = (state_ff == pms_pkg::ST_RUN);

    // size field is live for software, but the split only moves at the next reset;
    // it stands for a configuration byte, so reset must not clear it, else a written
    // size could never reach the split; unknown until software first writes it
    always_ff @(posedge ref_clk) begin
        if (rst_n && cfgWe) begin
            loaderSel_ff <= cfgWdata[pms_pkg::LDSEL_LSB +: pms_pkg::LDSEL_W];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfgRdata_ff <= 8'h00;
        end else begin
            cfgRdata_ff <= {5'h00, loaderSel_ff};
        end
    end

    // straps caught in the first clocked cycle after release, never by the reset itself
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bootSel_ff <= pms_pkg::LDSEL_RST;
            bootLoader_ff <= 1'b0;
        end else if (state_ff == pms_pkg::ST_BOOT) begin
            bootSel_ff <= loaderSel_ff;
            bootLoader_ff <= bootFromLoader && (loaderSel_ff != pms_pkg::LDSEL_NONE);
        end
    end

    assign loader_size_select = loaderBytes(bootSel_ff);
    assign ldBase = pms_pkg::FLASH_TOP - loader_size_select;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            resetPc_ff <= pms_pkg::RESET_PC;
        end else begin
            resetPc_ff <= bootLoader_ff ? ldBase : pms_pkg::RESET_PC;
        end
    end

    // vectors are logical addresses; the fetch path re-bases them into the loader area
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            vectorPc_ff <= pms_pkg::RESET_PC;
        end else if (vecReq) begin
            vectorPc_ff <= {8'h00, vecNum, pms_pkg::VEC_OFFSET};
        end
    end

    // logical program address to physical flash index
    always_comb begin
        physAddr = req.addr;
        physOk = 1'b1;
        if (req.op == pms_pkg::OP_FETCH || req.op == pms_pkg::OP_MOVC) begin
            if (bootLoader_ff) begin
                physAddr = ldBase + req.addr;
                physOk = (req.addr < loader_size_select);
            end else begin
                physOk = (req.addr < ldBase);
            end
        end else begin
            physOk = (req.addr < pms_pkg::FLASH_TOP);
        end
    end

    assign isSec = inSecure(req.addr);
    assign secured = (secMem_ff[pms_pkg::SEC_LAST_IDX] != pms_pkg::BYTE_ERASED);
    assign secAllowCpu = !secured || runFromSecure_ff;
    assign ispBlocked = secured && isSec;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            secured_ff <= 1'b0;
        end else begin
            secured_ff <= secured;
        end
    end

    // execution location follows the most recent fetch
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            runFromSecure_ff <= 1'b0;
        end else if (running && req.vld && req.op == pms_pkg::OP_FETCH) begin
            runFromSecure_ff <= isSec;
        end
    end

    // code flash: page erase, byte program, whole-chip erase
    always_ff @(posedge ref_clk) begin
        if (running && req.vld && !isSec && physOk) begin
            case (req.op)
                pms_pkg::OP_ISP_PROG, pms_pkg::OP_IAP_PROG: begin
                    flashMem_ff[physAddr[pms_pkg::FLASH_AW-1:0]] <= req.wdata;
                end
                pms_pkg::OP_ISP_ERASE, pms_pkg::OP_IAP_ERASE: begin
                    for (int i = 0; i < pms_pkg::PAGE_BYTES; i++) begin
                        flashMem_ff[{physAddr[pms_pkg::FLASH_AW-1:pms_pkg::PAGE_AW],
                            i[pms_pkg::PAGE_AW-1:0]}] <= pms_pkg::BYTE_ERASED;
                    end
                end
                pms_pkg::OP_CHIP_ERASE: begin
                    for (int i = 0; i < pms_pkg::FLASH_BYTES; i++) begin
                        flashMem_ff[i] <= pms_pkg::BYTE_ERASED;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // secure area: one page, untouched by whole-chip erase
    always_ff @(posedge ref_clk) begin
        if (running && req.vld && isSec) begin
            case (req.op)
                pms_pkg::OP_ISP_PROG: begin
                    if (!ispBlocked) begin
                        secMem_ff[req.addr[pms_pkg::PAGE_AW-1:0]] <= req.wdata;
                    end
                end
                pms_pkg::OP_IAP_PROG: begin
                    if (secAllowCpu) begin
                        secMem_ff[req.addr[pms_pkg::PAGE_AW-1:0]] <= req.wdata;
                    end
                end
                pms_pkg::OP_ISP_ERASE, pms_pkg::OP_IAP_ERASE: begin
                    if ((req.op == pms_pkg::OP_ISP_ERASE) ? !ispBlocked : secAllowCpu) begin
                        for (int i = 0; i < pms_pkg::SEC_BYTES; i++) begin
                            secMem_ff[i] <= pms_pkg::BYTE_ERASED;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // data RAMs live in their own address spaces
    always_ff @(posedge ref_clk) begin
        if (running && req.vld && req.op == pms_pkg::OP_IRAM_WR) begin
            iramMem_ff[req.addr[7:0]] <= req.wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (running && req.vld && req.op == pms_pkg::OP_EXTENDED_DATA_RAM_WR) begin
            xramMem_ff[req.addr[pms_pkg::EXTENDED_DATA_RAM_AW-1:0]] <= req.wdata;
        end
    end

    // answer path
    always_comb begin
        nxt_rsp.vld = running && req.vld;
        nxt_rsp.err = 1'b0;
        nxt_rsp.data = pms_pkg::BYTE_HIDDEN;
        case (req.op)
            pms_pkg::OP_FETCH: begin
                if (isSec) begin
                    nxt_rsp.data = (secured && debugConnected) ? pms_pkg::BYTE_HIDDEN
                        : secMem_ff[req.addr[pms_pkg::PAGE_AW-1:0]];
                end else if (physOk) begin
                    nxt_rsp.data = flashMem_ff[physAddr[pms_pkg::FLASH_AW-1:0]];
                end else begin
                    nxt_rsp.err = 1'b1;
                    nxt_rsp.data = pms_pkg::BYTE_ERASED;
                end
            end
            pms_pkg::OP_MOVC, pms_pkg::OP_IAP_RD: begin
                if (isSec) begin
                    nxt_rsp.data = secAllowCpu ? secMem_ff[req.addr[pms_pkg::PAGE_AW-1:0]]
                        : pms_pkg::BYTE_HIDDEN;
                end else if (physOk) begin
                    nxt_rsp.data = flashMem_ff[physAddr[pms_pkg::FLASH_AW-1:0]];
                end else begin
                    nxt_rsp.err = 1'b1;
                    nxt_rsp.data = pms_pkg::BYTE_ERASED;
                end
            end
            pms_pkg::OP_ISP_RD: begin
                if (isSec) begin
                    nxt_rsp.err = ispBlocked;
                    nxt_rsp.data = ispBlocked ? pms_pkg::BYTE_HIDDEN
                        : secMem_ff[req.addr[pms_pkg::PAGE_AW-1:0]];
                end else if (physOk) begin
                    nxt_rsp.data = flashMem_ff[physAddr[pms_pkg::FLASH_AW-1:0]];
                end else begin
                    nxt_rsp.err = 1'b1;
                    nxt_rsp.data = pms_pkg::BYTE_ERASED;
                end
            end
            pms_pkg::OP_ISP_PROG, pms_pkg::OP_ISP_ERASE: begin
                nxt_rsp.err = isSec ? ispBlocked : !physOk;
            end
            pms_pkg::OP_IAP_PROG, pms_pkg::OP_IAP_ERASE: begin
                nxt_rsp.err = isSec ? !secAllowCpu : !physOk;
            end
            pms_pkg::OP_IRAM_RD: begin
                nxt_rsp.data = iramMem_ff[req.addr[7:0]];
            end
            pms_pkg::OP_EXTENDED_DATA_RAM_RD: begin
                nxt_rsp.data = xramMem_ff[req.addr[pms_pkg::EXTENDED_DATA_RAM_AW-1:0]];
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff <= nxt_rsp;
        end
    end

    // checks
    reset_pc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_ff == pms_pkg::ST_RUN) |-> ##1 (resetPc_ff == ($past(bootLoader_ff) ?
        $past(ldBase) : 16'h0000)))
        else $error("reset fetch address wrong");
    vector_slot_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        vecReq |=> (vectorPc_ff[2:0] == 3'h3) && (vectorPc_ff[7:3] == $past(vecNum)))
        else $error("vector slot wrong");
    ram_space_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (running && req.vld && req.op == pms_pkg::OP_IRAM_WR) ##1
        (req.vld && req.op == pms_pkg::OP_IRAM_RD && req.addr[7:0] == $past(req.addr[7:0]))
        |=> rsp_ff.data == $past(req.wdata, 2))
        else $error("internal ram read back wrong");
    loader_base_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (bootSel_ff == 3'h6) |-> (ldBase == 16'h7c00))
        else $error("loader split wrong");
    sec_hide_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (running && req.vld && req.op == pms_pkg::OP_MOVC && isSec && secured
        && !runFromSecure_ff) |=> rsp_ff.vld && rsp_ff.data == 8'h00)
        else $error("secure data leaked");
    sec_debug_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (running && req.vld && req.op == pms_pkg::OP_FETCH && isSec && secured
        && debugConnected) |=> rsp_ff.data == 8'h00)
        else $error("secure fetch leaked to debug");
    sec_isp_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (running && req.vld && isSec && secured && (req.op == pms_pkg::OP_ISP_PROG
        || req.op == pms_pkg::OP_ISP_RD)) |=> rsp_ff.err ##1 $stable(secured_ff))
        else $error("secure programming not refused");
    chip_erase_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (running && req.vld && req.op == pms_pkg::OP_CHIP_ERASE)
        |=> $stable(secMem_ff[pms_pkg::SEC_LAST_IDX]))
        else $error("chip erase touched secure area");
    page_erase_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (running && req.vld && req.op == pms_pkg::OP_ISP_ERASE && !isSec && physOk)
        |=> flashMem_ff[{$past(physAddr[14:7]), 7'h7f}] == 8'hff)
        else $error("page erase incomplete");
    rsp_once_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !running |=> !rsp_ff.vld)
        else $error("answer before run");

    boot_loader_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        bootLoader_ff && rsp_ff.vld);
    secure_run_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        runFromSecure_ff && secured_ff && rsp_ff.vld);
    isp_refused_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        rsp_ff.vld && rsp_ff.err && secured_ff);
endmodule

//--- common/pms_pkg.sv
/*
 * pms_pkg: shared types and constants of the program memory map and secure area block.
 * Assumes a single 200 MHz clock domain and one request per cycle from the core side.
 */
package pms_pkg;
    // memory geometry
    localparam int FLASH_BYTES = 32768;
    localparam int FLASH_AW = 15;
    localparam int PAGE_BYTES = 128;
    localparam int PAGE_AW = 7;
    localparam int IRAM_BYTES = 256;
    localparam int EXTENDED_DATA_RAM_BYTES = 2048;
    localparam int EXTENDED_DATA_RAM_AW = 11;
    localparam int SEC_BYTES = 128;
    localparam logic [15:0] SEC_BASE = 16'hff80;
    localparam logic [6:0] SEC_LAST_IDX = 7'h7f;
    localparam logic [7:0] BYTE_ERASED = 8'hff;
    localparam logic [7:0] BYTE_HIDDEN = 8'h00;
    // program address map
    localparam logic [15:0] RESET_PC = 16'h0000;
    localparam logic [2:0] VEC_OFFSET = 3'h3;
    localparam logic [15:0] FLASH_TOP = 16'h8000;
    // loader_size_config: field in bits 2:0, reserved bits read zero
    localparam int LDSEL_LSB = 0;
    localparam int LDSEL_W = 3;
    localparam logic [2:0] LDSEL_RST = 3'h7;
    localparam logic [2:0] LDSEL_NONE = 3'h7;
    localparam logic [2:0] LDSEL_1K = 3'h6;
    localparam logic [2:0] LDSEL_2K = 3'h5;
    localparam logic [2:0] LDSEL_3K = 3'h4;
    localparam logic [15:0] LD_SIZE_0K = 16'h0000;
    localparam logic [15:0] LD_SIZE_1K = 16'h0400;
    localparam logic [15:0] LD_SIZE_2K = 16'h0800;
    localparam logic [15:0] LD_SIZE_3K = 16'h0c00;
    localparam logic [15:0] LD_SIZE_4K = 16'h1000;

    typedef enum logic [3:0] {
        OP_FETCH = 4'h0,
        OP_MOVC = 4'h1,
        OP_IRAM_RD = 4'h2,
        OP_IRAM_WR = 4'h3,
        OP_EXTENDED_DATA_RAM_RD = 4'h4,
        OP_EXTENDED_DATA_RAM_WR = 4'h5,
        OP_ISP_RD = 4'h6,
        OP_ISP_PROG = 4'h7,
        OP_ISP_ERASE = 4'h8,
        OP_CHIP_ERASE = 4'h9,
        OP_IAP_RD = 4'ha,
        OP_IAP_PROG = 4'hb,
        OP_IAP_ERASE = 4'hc
    } pms_op_t;

    typedef enum logic [1:0] {
        ST_BOOT = 2'b00,
        ST_RUN = 2'b01
    } pms_state_t;

    typedef struct packed {
        logic vld;
        pms_op_t op;
        logic [15:0] addr;
        logic [7:0] wdata;
    } pms_req_t;

    typedef struct packed {
        logic vld;
        logic err;
        logic [7:0] data;
    } pms_rsp_t;
endpackage

//--- sim/pms_core_model.sv
/*
 * pms_core_model: behavioural requester on the memory port, standing in for the cpu core,
 * the in-system programming path and the in-application programming path.
 * Assumes the bench calls its tasks in order and that requests change at the falling edge.
 */
`timescale 1ns/1ps
module pms_core_model (
    // clock
    input wire logic ref_clk,
    // request towards the block
    output pms_pkg::pms_req_t req
);
    initial req = '0;

    // one request per call; back-to-back calls keep vld high every cycle
    task automatic issue(input pms_pkg::pms_op_t op, input logic [15:0] addr,
                         input logic [7:0] wdata);
        @(negedge ref_clk);
        req = '{vld: 1'b1, op: op, addr: addr, wdata: wdata};
    endtask

    // released fields are inverted once on release so nothing can lean on a stale address or byte
    task automatic idle();
        @(negedge ref_clk);
        req.vld = 1'b0;
        req.addr = ~req.addr;
        req.wdata = ~req.wdata;
    endtask
endmodule

//--- sim/tb_pms_memory_map.sv
/*
 * tb_pms_memory_map: self-checking bench for the memory map and secure area block.
 * Assumes pms_pkg is compiled first and the core model drives the memory port.
 */
`timescale 1ns/1ps
module tb_pms_memory_map;
    typedef struct packed {
        logic err;
        logic [7:0] data;
        logic chk;
    } pms_exp_t;

    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic bootFromLoader = 1'b0;
    logic debugConnected = 1'b0;
    logic cfgWe = 1'b0;
    logic [7:0] cfgWdata = 8'h00;
    logic vecReq = 1'b0;
    logic [4:0] vecNum = 5'h00;
    logic [7:0] cfgRdata_ff;
    logic [15:0] vectorPc_ff;
    logic [15:0] resetPc_ff;
    logic secured_ff;
    logic bootLoader_ff;
    logic runFromSecure_ff;
    pms_pkg::pms_req_t req;
    pms_pkg::pms_rsp_t rsp_ff;
    pms_exp_t expQ[$];
    int failCount = 0;
    int nTests = 0;
    int cycles = 0;
    int seed = 32'h954c4939;
    logic [7:0] r [0:7];
    logic [2:0] codes [0:5] = '{3'h7, 3'h5, 3'h4, 3'h0, 3'h3, 3'h6};
    logic [15:0] sizes [0:5] = '{16'h0000, 16'h0800, 16'h0c00, 16'h1000, 16'h1000, 16'h0400};

    always #2.5 ref_clk = ~ref_clk;

    pms_memory_map dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .bootFromLoader(bootFromLoader),
        .debugConnected(debugConnected), .cfgWe(cfgWe), .cfgWdata(cfgWdata),
        .cfgRdata_ff(cfgRdata_ff), .vecReq(vecReq), .vecNum(vecNum),
        .vectorPc_ff(vectorPc_ff), .req(req), .rsp_ff(rsp_ff), .resetPc_ff(resetPc_ff),
        .secured_ff(secured_ff), .bootLoader_ff(bootLoader_ff),
        .runFromSecure_ff(runFromSecure_ff)
    );

    pms_core_model core (
        .ref_clk(ref_clk),
        .req(req)
    );

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nTests++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value at %0t: status got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkRsp(input pms_pkg::pms_rsp_t got, input pms_exp_t exp);
        nTests++;
        if (got.err !== exp.err || (exp.chk && got.data !== exp.data)) begin
            failCount++;
            $display("wrong value at %0t: answer err %b data %h expected err %b data %h",
                     $time, got.err, got.data, exp.err, exp.data);
        end
    endtask

    task automatic testDone();
        $display("comparisons %0d mismatches %0d", nTests, failCount);
        if (failCount == 0 && nTests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // expectation noted before the request goes out; the monitor pairs them in order
    task automatic rq(input pms_pkg::pms_op_t op, input logic [15:0] a, input logic [7:0] d,
                      input logic e, input logic [7:0] x, input logic c);
        expQ.push_back('{err: e, data: x, chk: c});
        core.issue(op, a, d);
    endtask

    task automatic drain();
        core.idle();
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic doReset(input logic ldr);
        @(negedge ref_clk);
        rst_n = 1'b0;
        bootFromLoader = ldr;
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
    endtask

    task automatic cfgWrite(input logic [2:0] code);
        logic [7:0] junk;
        junk = $random(seed);
        @(negedge ref_clk);
        cfgWe = 1'b1;
        cfgWdata = {junk[7:3], code};
        @(negedge ref_clk);
        cfgWe = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk({8'h00, cfgRdata_ff}, {13'h0000, code});
    endtask

    always @(negedge ref_clk) begin
        if (rsp_ff.vld === 1'b1) begin
            if (expQ.size() == 0) begin
                failCount++;
                $display("wrong value at %0t: answer with nothing outstanding", $time);
            end else begin
                chkRsp(rsp_ff, expQ.pop_front());
            end
        end
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 4000) begin
            failCount++;
            $display("wrong value at %0t: run did not finish in time", $time);
            testDone();
        end
    end

    initial begin
        for (int i = 0; i < 8; i++) begin
            r[i] = $random(seed);
        end
        repeat (6) @(posedge ref_clk);
        doReset(1'b0);
        chk(resetPc_ff, 16'h0000);
        cfgWrite(3'h7);
        // six size codes covering every loader size, each followed by a reset with the loader strap set
        for (int i = 0; i < 6; i++) begin
            cfgWrite(codes[i]);
            doReset(1'b1);
            chk(resetPc_ff, (sizes[i] == 16'h0000) ? 16'h0000 : 16'h8000 - sizes[i]);
            chk({15'h0000, bootLoader_ff}, {15'h0000, sizes[i] != 16'h0000});
        end
        rq(pms_pkg::OP_ISP_PROG, 16'h7c00, r[0], 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_FETCH, 16'h0000, 8'h00, 1'b0, r[0], 1'b1);
        rq(pms_pkg::OP_FETCH, 16'h0400, 8'h00, 1'b1, 8'hff, 1'b1);
        drain();
        for (int n = 0; n < 32; n++) begin
            @(negedge ref_clk);
            vecReq = 1'b1;
            vecNum = n[4:0];
            @(negedge ref_clk);
            vecReq = 1'b0;
            chk(vectorPc_ff, 16'(n * 8 + 3));
        end
        doReset(1'b0);
        chk({15'h0000, bootLoader_ff}, 16'h0000);
        rq(pms_pkg::OP_ISP_PROG, 16'h0100, r[1], 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_ISP_PROG, 16'h017f, r[2], 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_ISP_PROG, 16'h0180, r[3], 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_ISP_RD, 16'h017f, 8'h00, 1'b0, r[2], 1'b1);
        rq(pms_pkg::OP_ISP_ERASE, 16'h0100, 8'h00, 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_ISP_RD, 16'h0100, 8'h00, 1'b0, 8'hff, 1'b1);
        rq(pms_pkg::OP_ISP_RD, 16'h017f, 8'h00, 1'b0, 8'hff, 1'b1);
        rq(pms_pkg::OP_FETCH, 16'h0180, 8'h00, 1'b0, r[3], 1'b1);
        rq(pms_pkg::OP_MOVC, 16'h0180, 8'h00, 1'b0, r[3], 1'b1);
        rq(pms_pkg::OP_IAP_PROG, 16'h0200, r[4], 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_IAP_RD, 16'h0200, 8'h00, 1'b0, r[4], 1'b1);
        rq(pms_pkg::OP_ISP_PROG, 16'h7bff, r[5], 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_FETCH, 16'h7bff, 8'h00, 1'b0, r[5], 1'b1);
        rq(pms_pkg::OP_FETCH, 16'h7c00, 8'h00, 1'b1, 8'hff, 1'b1);
        rq(pms_pkg::OP_IRAM_WR, 16'h00ff, r[6], 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_EXTENDED_DATA_RAM_WR, 16'h00ff, r[7], 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_EXTENDED_DATA_RAM_WR, 16'h07ff, r[1], 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_IRAM_RD, 16'h00ff, 8'h00, 1'b0, r[6], 1'b1);
        rq(pms_pkg::OP_EXTENDED_DATA_RAM_RD, 16'h00ff, 8'h00, 1'b0, r[7], 1'b1);
        rq(pms_pkg::OP_EXTENDED_DATA_RAM_RD, 16'h07ff, 8'h00, 1'b0, r[1], 1'b1);
        // leave the secure area non-secured by erasing it from code running inside it
        rq(pms_pkg::OP_FETCH, 16'hff80, 8'h00, 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_IAP_ERASE, 16'hff80, 8'h00, 1'b0, 8'h00, 1'b0);
        drain();
        chk({15'h0000, secured_ff}, 16'h0000);
        rq(pms_pkg::OP_ISP_PROG, 16'hff80, 8'h5a, 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_ISP_RD, 16'hff80, 8'h00, 1'b0, 8'h5a, 1'b1);
        rq(pms_pkg::OP_ISP_PROG, 16'hffff, r[2] & 8'h7f, 1'b0, 8'h00, 1'b0);
        drain();
        chk({15'h0000, secured_ff}, 16'h0001);
        rq(pms_pkg::OP_ISP_RD, 16'hff80, 8'h00, 1'b1, 8'h00, 1'b1);
        rq(pms_pkg::OP_ISP_PROG, 16'hff81, 8'h33, 1'b1, 8'h00, 1'b0);
        rq(pms_pkg::OP_ISP_ERASE, 16'hff80, 8'h00, 1'b1, 8'h00, 1'b0);
        rq(pms_pkg::OP_FETCH, 16'h0180, 8'h00, 1'b0, r[3], 1'b1);
        rq(pms_pkg::OP_MOVC, 16'hff80, 8'h00, 1'b0, 8'h00, 1'b1);
        rq(pms_pkg::OP_FETCH, 16'hff90, 8'h00, 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_MOVC, 16'hff80, 8'h00, 1'b0, 8'h5a, 1'b1);
        rq(pms_pkg::OP_MOVC, 16'hff81, 8'h00, 1'b0, 8'hff, 1'b1);
        drain();
        chk({15'h0000, runFromSecure_ff}, 16'h0001);
        debugConnected = 1'b1;
        rq(pms_pkg::OP_FETCH, 16'hff80, 8'h00, 1'b0, 8'h00, 1'b1);
        drain();
        debugConnected = 1'b0;
        rq(pms_pkg::OP_CHIP_ERASE, 16'h0000, 8'h00, 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_ISP_RD, 16'h0180, 8'h00, 1'b0, 8'hff, 1'b1);
        rq(pms_pkg::OP_FETCH, 16'hff80, 8'h00, 1'b0, 8'h5a, 1'b1);
        rq(pms_pkg::OP_IRAM_RD, 16'h00ff, 8'h00, 1'b0, r[6], 1'b1);
        rq(pms_pkg::OP_IRAM_WR, 16'h0010, r[5], 1'b0, 8'h00, 1'b0);
        rq(pms_pkg::OP_IRAM_RD, 16'h0010, 8'h00, 1'b0, r[5], 1'b1);
        drain();
        chk({15'h0000, secured_ff}, 16'h0001);
        chk(16'(expQ.size()), 16'h0000);
        testDone();
    end
endmodule
